// file: verilog/pxl_readout.sv
// proximity LED pulse timing, sample delay and light result readout
`timescale 1ns/1ps
// Behaviour
// - led rate is 4 MHz over divider
// - divider resets to 16, 250 kHz
// - receiver samples delayed from the latest LED edge
// - delay register resets to code 5
// - LED current modulated, amplitude programmable
// - proximity result is 12-bit unsigned
// - proximity result stored, host readable
// - light channels enabled independently, else powered down
// - each light channel stores 16-bit result
// - proximity msb at 0x41, lsb at 0x42
module pxl_readout (
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          clk_en,
    // register access port
    input  wire pxl_pkg::pxl_req_t             reg_req,
    output logic [7:0]                         reg_rdata,
    output logic                               reg_rvalid,
    // measurement control
    input  wire logic                          prox_active,
    input  wire pxl_pkg::pxl_conv_t            conv,
    // LED driver and receiver
    output logic                               led_drive,
    output logic [pxl_pkg::PXL_CUR_W-1:0]      led_current,
    output logic                               rx_sample,
    // light channel power
    output logic                               filt_light_pwr,
    output logic                               unf_light_pwr
);
    import pxl_pkg::*;

    logic [7:0]             led_pulse_divider_q;
    logic [7:0]             receiver_sample_delay_q;
    logic [7:0]             led_current_q;
    logic [7:0]             light_ctrl_q;
    logic [PXL_PROX_W-1:0]  proximity_result_q;
    logic [PXL_LIGHT_W-1:0] filtered_light_result_q;
    logic [PXL_LIGHT_W-1:0] unfiltered_light_result_q;
    logic [7:0]             ref_cnt_q;
    logic [PXL_DLY_W-1:0]   dly_cnt_q;
    logic                   led_q;
    logic                   led_edge_q;
    pxl_smp_st_t            smp_st_q;
    logic                   ref_tick;
    logic                   step_tick;
    logic [7:0]             half_cnt;

    // decodes the number of 125 ns steps for a delay code
    // only the low five code bits count; larger codes fold onto them
    function automatic logic [PXL_DLY_W-1:0] dly_steps(input logic [7:0] code);
        logic [PXL_DLY_W-1:0] c;
        c = code[PXL_DLY_W-1:0];
        if (c <= PXL_DLY_W'(1))
            dly_steps = '0;
        else
            dly_steps = c - PXL_DLY_W'(1);
    endfunction

    // reference and step tick source
    // every reference tick is also a step tick, so LED edges land on step boundaries
    pxl_ref_tick #(
        .ACC_W     (8)
    ) u_tick (
        .clk       (clk),
        .rst_n     (rst_n),
        .clk_en    (clk_en),
        .ref_tick  (ref_tick),
        .step_tick (step_tick)
    );

    // register writes
    // result offsets are read only; a write to them falls to the default arm
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            led_pulse_divider_q     <= PXL_RST_LED_DIV;
            receiver_sample_delay_q <= PXL_RST_SMP_DELAY;
            led_current_q           <= PXL_RST_LED_CURRENT;
            light_ctrl_q            <= PXL_RST_LIGHT_CTRL;
        end else if (clk_en && reg_req.wr) begin
            case (reg_req.addr)
                PXL_OFF_LED_DIV:     led_pulse_divider_q     <= reg_req.wdata;
                PXL_OFF_SMP_DELAY:   receiver_sample_delay_q <= reg_req.wdata;
                PXL_OFF_LED_CURRENT: led_current_q           <= reg_req.wdata;
                PXL_OFF_LIGHT_CTRL:  light_ctrl_q            <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // register reads, answered one cycle after the request
    // read data follows the address every enabled cycle; only rvalid marks it
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata  <= 8'h00;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_req.rd;
            case (reg_req.addr)
                PXL_OFF_LED_DIV:     reg_rdata <= led_pulse_divider_q;
                PXL_OFF_SMP_DELAY:   reg_rdata <= receiver_sample_delay_q;
                PXL_OFF_LED_CURRENT: reg_rdata <= led_current_q;
                PXL_OFF_LIGHT_CTRL:  reg_rdata <= light_ctrl_q;
                PXL_OFF_PROX_MSB:    reg_rdata <= 8'(proximity_result_q[PXL_PROX_W-1:8]);
                PXL_OFF_PROX_LSB:    reg_rdata <= proximity_result_q[7:0];
                PXL_OFF_FILT_MSB:    reg_rdata <= filtered_light_result_q[15:8];
                PXL_OFF_FILT_LSB:    reg_rdata <= filtered_light_result_q[7:0];
                PXL_OFF_UNF_MSB:     reg_rdata <= unfiltered_light_result_q[15:8];
                PXL_OFF_UNF_LSB:     reg_rdata <= unfiltered_light_result_q[7:0];
                default:             reg_rdata <= 8'h00;
            endcase
        end
    end

    // conversion results; a powered-down channel keeps its last value
    // a disabled channel ignores its converter so a stray valid cannot overwrite
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            proximity_result_q        <= '0;
            filtered_light_result_q   <= '0;
            unfiltered_light_result_q <= '0;
        end else if (clk_en) begin
            if (conv.prox_vld)
                proximity_result_q <= conv.prox;
            if (conv.filt_vld && light_ctrl_q[PXL_BIT_FILT_EN])
                filtered_light_result_q <= conv.filt;
            if (conv.unf_vld && light_ctrl_q[PXL_BIT_UNF_EN])
                unfiltered_light_result_q <= conv.unf;
        end
    end

    // light channel power enables
    // power follows the enable bits one cycle late, straight from a flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            filt_light_pwr <= 1'b0;
            unf_light_pwr  <= 1'b0;
        end else if (clk_en) begin
            filt_light_pwr <= light_ctrl_q[PXL_BIT_FILT_EN];
            unf_light_pwr  <= light_ctrl_q[PXL_BIT_UNF_EN];
        end
    end

    assign half_cnt = {1'b0, led_pulse_divider_q[7:1]};

    // LED pulse divider: period of divider reference ticks, high for half
    // an edge is flagged only on a real level change, so an idle start samples nothing
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_cnt_q  <= 8'h00;
            led_q      <= 1'b0;
            led_edge_q <= 1'b0;
        end else if (clk_en) begin
            led_edge_q <= 1'b0;
            if (!prox_active) begin
                ref_cnt_q <= 8'h00;
                led_q     <= 1'b0;
            end else if (ref_tick) begin
                if (ref_cnt_q + 8'h01 >= led_pulse_divider_q) begin
                    ref_cnt_q  <= 8'h00;
                    led_q      <= 1'b1;
                    led_edge_q <= !led_q;
                end else begin
                    ref_cnt_q <= ref_cnt_q + 8'h01;
                    if (ref_cnt_q + 8'h01 == half_cnt) begin
                        led_q      <= 1'b0;
                        led_edge_q <= led_q;
                    end
                end
            end
        end
    end

    // LED drive and current outputs
    // the drive lags the internal level by one clock, and the sample timer too
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            led_drive   <= 1'b0;
            led_current <= '0;
        end else if (clk_en) begin
            led_drive   <= led_q;
            led_current <= led_current_q[PXL_CUR_W-1:0];
        end
    end

    // sample delay timer, restarted at every LED edge
    // a new edge overrides a pending wait, so only the latest edge is sampled
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            smp_st_q  <= PXL_ST_IDLE;
            dly_cnt_q <= '0;
            rx_sample <= 1'b0;
        end else if (clk_en) begin
            rx_sample <= 1'b0;
            if (led_edge_q) begin
                dly_cnt_q <= dly_steps(receiver_sample_delay_q);
                smp_st_q  <= PXL_ST_WAIT;
            end else begin
                case (smp_st_q)
                    PXL_ST_IDLE: ;
                    PXL_ST_WAIT: begin
                        if (dly_cnt_q == '0) begin
                            rx_sample <= 1'b1;
                            smp_st_q  <= PXL_ST_DONE;
                        end else if (step_tick) begin
                            dly_cnt_q <= dly_cnt_q - PXL_DLY_W'(1);
                        end
                    end
                    PXL_ST_DONE: smp_st_q <= PXL_ST_IDLE;
                    default:     smp_st_q <= PXL_ST_IDLE;
                endcase
            end
        end
    end
endmodule

// file: pkg/pxl_pkg.sv
// package: register map, reset values, timing constants and carrier types for the sensor readout
package pxl_pkg;

    // register offsets
    localparam logic [7:0] PXL_OFF_LED_DIV      = 8'h0D;
    localparam logic [7:0] PXL_OFF_SMP_DELAY    = 8'h0E;
    localparam logic [7:0] PXL_OFF_LED_CURRENT  = 8'h0F;
    localparam logic [7:0] PXL_OFF_LIGHT_CTRL   = 8'h27;
    localparam logic [7:0] PXL_OFF_PROX_MSB     = 8'h41;
    localparam logic [7:0] PXL_OFF_PROX_LSB     = 8'h42;
    localparam logic [7:0] PXL_OFF_FILT_MSB     = 8'h43;
    localparam logic [7:0] PXL_OFF_FILT_LSB     = 8'h44;
    localparam logic [7:0] PXL_OFF_UNF_MSB      = 8'h45;
    localparam logic [7:0] PXL_OFF_UNF_LSB      = 8'h46;

    // reset values
    localparam logic [7:0] PXL_RST_LED_DIV      = 8'h10;
    localparam logic [7:0] PXL_RST_SMP_DELAY    = 8'h05;
    localparam logic [7:0] PXL_RST_LED_CURRENT  = 8'h00;
    localparam logic [7:0] PXL_RST_LIGHT_CTRL   = 8'h00;

    // field positions in the light control register
    localparam int PXL_BIT_FILT_EN = 0;
    localparam int PXL_BIT_UNF_EN  = 1;

    // field widths
    localparam int PXL_CUR_W   = 4;
    localparam int PXL_DLY_W   = 5;
    localparam int PXL_PROX_W  = 12;
    localparam int PXL_LIGHT_W = 16;

    // timing: reference and step figures in their own units
    localparam int PXL_CLK_MHZ      = 50;
    localparam int PXL_REF_MHZ      = 4;
    localparam int PXL_STEP_NS      = 125;
    localparam int PXL_CLK_PER_NS   = 20;
    // nanoseconds per half reference period, 125 ns (4 MHz ref built from 50 MHz)
    localparam int PXL_REF_HALF_NS  = 1000 / (2 * PXL_REF_MHZ);
    // 125 ns step, rounded down to whole clocks, at least one
    localparam int PXL_STEP_CYC     = (PXL_STEP_NS / PXL_CLK_PER_NS) < 1 ? 1 :
                                      (PXL_STEP_NS / PXL_CLK_PER_NS);

    // register bus carrier
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pxl_req_t;

    // conversion results from the analog converters
    typedef struct packed {
        logic                   prox_vld;
        logic [PXL_PROX_W-1:0]  prox;
        logic                   filt_vld;
        logic [PXL_LIGHT_W-1:0] filt;
        logic                   unf_vld;
        logic [PXL_LIGHT_W-1:0] unf;
    } pxl_conv_t;

    // state of the receiver sample delay timer
    typedef enum logic [2:0] {
        PXL_ST_IDLE  = 3'b001,
        PXL_ST_WAIT  = 3'b010,
        PXL_ST_DONE  = 3'b100
    } pxl_smp_st_t;

endpackage

// file: verilog/pxl_ref_tick.sv
// reference tick generator: 4 MHz ticks and 125 ns steps from the system clock
`timescale 1ns/1ps
module pxl_ref_tick #(
    parameter int ACC_W = 8
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic clk_en,
    // ticks out
    output logic      ref_tick,
    output logic      step_tick
);
    import pxl_pkg::*;

    // fractional accumulator: steps of 8 MHz (125 ns) from 50 MHz
    localparam logic [ACC_W-1:0] INC = ACC_W'(2 * PXL_REF_MHZ);
    localparam logic [ACC_W-1:0] MOD = ACC_W'(PXL_CLK_MHZ);

    logic [ACC_W-1:0] acc_q;
    logic             half_q;
    logic [ACC_W:0]   sum;

    assign sum = {1'b0, acc_q} + {1'b0, INC};

    // step accumulator; every second step is a reference tick
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q     <= '0;
            half_q    <= 1'b0;
            step_tick <= 1'b0;
            ref_tick  <= 1'b0;
        end else if (clk_en) begin
            step_tick <= 1'b0;
            ref_tick  <= 1'b0;
            if (sum >= {1'b0, MOD}) begin
                acc_q     <= ACC_W'(sum - {1'b0, MOD});
                step_tick <= 1'b1;
                half_q    <= ~half_q;
                ref_tick  <= half_q;
            end else begin
                acc_q <= sum[ACC_W-1:0];
            end
        end
    end
endmodule

// file: bench/pxl_readout_properties.sv
// checker: port-level timing properties of the readout block
`timescale 1ns/1ps
module pxl_readout_checker (
    // clock and reset
    input wire logic                         clk,
    input wire logic                         rst_n,
    input wire logic                         clk_en,
    // register port
    input wire pxl_pkg::pxl_req_t            reg_req,
    input wire logic [7:0]                   reg_rdata,
    input wire logic                         reg_rvalid,
    // measurement and outputs
    input wire logic                         prox_active,
    input wire logic                         led_drive,
    input wire logic [pxl_pkg::PXL_CUR_W-1:0] led_current,
    input wire logic                         rx_sample,
    input wire logic                         filt_light_pwr,
    input wire logic                         unf_light_pwr
);
    import pxl_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    logic [1:0] wr_ctl_q;
    logic [1:0] wr_cur_q;
    // recent writes to the light control and current registers
    always_ff @(posedge clk) begin
        wr_ctl_q <= {wr_ctl_q[0], clk_en && reg_req.wr && reg_req.addr == PXL_OFF_LIGHT_CTRL};
        wr_cur_q <= {wr_cur_q[0], clk_en && reg_req.wr && reg_req.addr == PXL_OFF_LED_CURRENT};
    end
    sequence s_rd_any;
        clk_en && reg_req.rd;
    endsequence
    sequence s_rd_prox;
        s_rd_any ##0 reg_req.addr == PXL_OFF_PROX_MSB;
    endsequence
    property p_rd_answer; s_rd_any |=> reg_rvalid; endproperty
    property p_rvalid_pulse; (clk_en && !reg_req.rd) |=> !reg_rvalid; endproperty
    property p_prox_msb; s_rd_prox |=> reg_rdata[7:4] == 4'h0; endproperty
    property p_led_off; !prox_active [*3] |-> !led_drive; endproperty
    property p_led_width; $rose(led_drive) |=> (led_drive || !prox_active) [*8]; endproperty
    property p_rx_pulse; (rx_sample && clk_en) |=> !rx_sample; endproperty
    property p_pwr; $changed({filt_light_pwr, unf_light_pwr}) |-> wr_ctl_q != 2'h0; endproperty
    property p_cur; $changed(led_current) |-> wr_cur_q != 2'h0; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
    a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("stray valid");
    a_prox_msb: assert property (p_prox_msb) else $error("prox msb too wide");
    a_led_off: assert property (p_led_off) else $error("led on while idle");
    a_led_width: assert property (p_led_width) else $error("led pulse short");
    a_rx_pulse: assert property (p_rx_pulse) else $error("sample not a pulse");
    a_pwr: assert property (p_pwr) else $error("power changed unasked");
    a_cur: assert property (p_cur) else $error("current changed unasked");
endmodule

// file: bench/pxl_conv_model.sv
// conversion model: receivers deliver a result after a chosen latency
`timescale 1ns/1ps
module pxl_conv_model (
    // clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // request: channels {unf, filt, prox}, latency, value
    input  wire logic          start,
    input  wire logic [2:0]    sel,
    input  wire logic [3:0]    lat,
    input  wire logic [15:0]   val,
    // results to the block
    output pxl_pkg::pxl_conv_t conv
);
    import pxl_pkg::*;
    logic [4:0] cnt_q;
    logic       fire;
    // latency counter, bit 4 marks a pending result
    always_ff @(posedge clk) begin
        if (!rst_n || fire) begin
            cnt_q <= 5'h00;
        end else if (start) begin
            cnt_q <= {1'b1, lat};
        end else if (cnt_q[4]) begin
            cnt_q <= cnt_q - 5'h01;
        end
    end
    assign fire = (cnt_q == 5'h10);
    // outside the valid cycle the data lines carry the inverse value
    assign conv = {fire & sel[0], fire ? val[11:0] : ~val[11:0], fire & sel[1],
                   fire ? val : ~val, fire & sel[2], fire ? val : ~val};
endmodule

// file: bench/tb_top.sv
// testbench: registers, LED timing and result readout of the readout block
`timescale 1ns/1ps
module tb_top;
    import pxl_pkg::*;
    logic        clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, prox_active = 1'b0;
    pxl_req_t    req = '0;
    pxl_conv_t   conv;
    logic [7:0]  rdata;
    logic [3:0]  cur;
    logic        rvalid, led, rx, fpwr, upwr, m_start = 1'b0;
    logic [2:0]  m_sel = 3'h0;
    logic [3:0]  m_lat = 4'h0;
    logic [15:0] m_val = 16'h0000, pf = 16'h0000, pu = 16'h0000;
    int          errors = 0, num_checks = 0, cyc = 0;
    // 50 MHz clock
    always #10 clk = ~clk;
    pxl_readout dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_req(req), .reg_rdata(rdata),
        .reg_rvalid(rvalid), .prox_active(prox_active), .conv(conv), .led_drive(led),
        .led_current(cur), .rx_sample(rx), .filt_light_pwr(fpwr), .unf_light_pwr(upwr));
    pxl_conv_model u_model (.clk(clk), .rst_n(rst_n), .start(m_start), .sel(m_sel),
        .lat(m_lat), .val(m_val), .conv(conv));
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_of_test();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic near(input string nm, input int e, input int g, input int t);
        num_checks++;
        if (g < e - t || g > e + t) begin
            errors++;
            $display("BAD %s exp %0d got %0d", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        req = '0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        req = '0;
        chk($sformatf("reg %h", a), e, rdata);
        chk("rvalid", 1'b1, rvalid);
    endtask
    task automatic send(input logic [2:0] s, input logic [15:0] v, input logic [3:0] l);
        @(negedge clk);
        {m_sel, m_val, m_lat, m_start} = {s, v, l, 1'b1};
        @(negedge clk);
        m_start = 1'b0;
        repeat (l + 3) @(negedge clk);
    endtask
    // last period, high width and edge-to-sample distance in clocks
    task automatic measure(output int per, output int hi, output int dly);
        int   r1, te;
        logic pl;
        {r1, te, per, hi, dly} = {-32'sd1, -32'sd1, 32'd0, 32'd0, -32'sd1};
        pl = led;
        for (int c = 0; c < 640; c++) begin
            @(negedge clk);
            if (led !== pl) te = c;
            if (led === 1'b1 && pl === 1'b0) begin
                if (r1 >= 0) per = c - r1;
                r1 = c;
            end
            if (led === 1'b0 && pl === 1'b1 && r1 >= 0) hi = c - r1;
            if (rx === 1'b1 && te >= 0) dly = c - te;
            pl = led;
        end
    endtask
    task automatic t_regs();
        rdchk(PXL_OFF_LED_DIV, 8'h10);
        rdchk(PXL_OFF_SMP_DELAY, 8'h05);
        rdchk(PXL_OFF_LIGHT_CTRL, 8'h00);
        rdchk(8'h7F, 8'h00);
        wr(PXL_OFF_PROX_MSB, 8'hFF);
        rdchk(PXL_OFF_PROX_MSB, 8'h00);
        wr(PXL_OFF_LED_CURRENT, 8'hA7);
        repeat (2) @(negedge clk);
        chk("led current", 4'h7, cur);
    endtask
    task automatic t_timing();
        logic [7:0] dv [5] = '{8'h10, 8'h10, 8'h10, 8'h08, 8'h04};
        logic [7:0] cd [5] = '{8'h05, 8'h01, 8'h07, 8'h03, 8'h03};
        int per, hi, dly;
        for (int i = 0; i < 5; i++) begin
            prox_active = 1'b0;
            wr(PXL_OFF_SMP_DELAY, cd[i]);
            wr(PXL_OFF_LED_DIV, dv[i]);
            rdchk(PXL_OFF_SMP_DELAY, cd[i]);
            prox_active = 1'b1;
            measure(per, hi, dly);
            near("period", dv[i] * 25 / 2, per, 2);
            near("width", dv[i] * 25 / 4, hi, 2);
            near("delay", (cd[i] < 2) ? 0 : (cd[i] - 1) * 125 / 20, dly, 3);
        end
        prox_active = 1'b0;
        repeat (4) @(negedge clk);
        chk("led idle", 1'b0, led);
    endtask
    task automatic t_results();
        logic [15:0] v;
        send(3'h1, 16'hFABC, 4'h0);
        rdchk(PXL_OFF_PROX_MSB, 8'h0A);
        rdchk(PXL_OFF_PROX_LSB, 8'hBC);
        send(3'h1, 16'h0123, 4'h9);
        rdchk(PXL_OFF_PROX_MSB, 8'h01);
        rdchk(PXL_OFF_PROX_LSB, 8'h23);
        for (int en = 0; en < 4; en++) begin
            wr(PXL_OFF_LIGHT_CTRL, 8'(en));
            v = 16'h1A5C + 16'(en * 16'h2222);
            send(3'h6, v, 4'h2);
            if (en[0]) pf = v;
            if (en[1]) pu = v;
            chk("filt power", 16'(en[0]), fpwr);
            chk("unf power", 16'(en[1]), upwr);
            rdchk(PXL_OFF_FILT_MSB, pf[15:8]);
            rdchk(PXL_OFF_FILT_LSB, pf[7:0]);
            rdchk(PXL_OFF_UNF_MSB, pu[15:8]);
            rdchk(PXL_OFF_UNF_LSB, pu[7:0]);
        end
    endtask
    // clock enable freeze, then a reset in mid-run
    task automatic t_freeze();
        int   per, hi, dly;
        logic l0;
        prox_active = 1'b1;
        repeat (30) @(negedge clk);
        clk_en = 1'b0;
        l0 = led;
        wr(PXL_OFF_LED_DIV, 8'h08);
        repeat (60) @(negedge clk);
        chk("frozen led", l0, led);
        clk_en = 1'b1;
        rdchk(PXL_OFF_LED_DIV, 8'h04);
        measure(per, hi, dly);
        near("period after freeze", 50, per, 2);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        chk("led after reset", 1'b0, led);
        chk("filt power after reset", 1'b0, fpwr);
        rdchk(PXL_OFF_LED_DIV, 8'h10);
        rdchk(PXL_OFF_SMP_DELAY, 8'h05);
        rdchk(PXL_OFF_PROX_LSB, 8'h00);
    endtask
    // main sequence
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        t_regs();
        t_timing();
        t_results();
        t_freeze();
        end_of_test();
    end
endmodule
bind pxl_readout pxl_readout_checker u_chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .prox_active(prox_active), .led_drive(led_drive), .led_current(led_current),
    .rx_sample(rx_sample), .filt_light_pwr(filt_light_pwr), .unf_light_pwr(unf_light_pwr));
